/* File: verilog/iob_pkg.sv */
// Contract
// - slot address match enables data buffer
// - three address lines pick one function
// - board-type read returns fixed identity number
// - acknowledge returned, also clears the watchdog
// - no acknowledge before timeout raises bus fault
// - 16 MHz source divided to 8/4/2 MHz
// - 175 ms reset pulse 5 ms after power
// - pushbutton triggers the same reset pulse
// - all six supplies good lights indicator
// - quadrature phase gives direction, pulses counted
// - encoder activity raises interrupt line three
// - keypad columns pulsed in turn, rows sensed
// - key closure raises interrupt line four
// - keypad read presents key code
// - counter outputs ORed with interrupt line six
// - mask bit high forces line inactive
// - seven masked lines encoded to three bits
// - only the highest pending level presented
package iob_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int POR_DELAY_MS = 5;
  localparam int POR_PULSE_MS = 175;
  localparam int POR_DELAY_CYC = (POR_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int POR_PULSE_CYC = (POR_PULSE_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BUS_TIMEOUT_NS = 10000;
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int KEY_COL_NS = 4000;
  localparam int KEY_COL_CYC = KEY_COL_NS / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 23;
  localparam int WDOG_W = 8;
  localparam int KEY_TMR_W = 7;
  localparam logic [WDOG_W-1:0] WDOG_LAST = WDOG_W'(BUS_TIMEOUT_CYC - 1);
  localparam logic [KEY_TMR_W-1:0] KEY_TMR_LAST = KEY_TMR_W'(KEY_COL_CYC - 1);

  // ----------------------------------------------------------------
  // function codes on the three function address lines
  // ----------------------------------------------------------------
  localparam logic [2:0] FN_KEYPAD = 3'h0;
  localparam logic [2:0] FN_ENCODER = 3'h1;
  localparam logic [2:0] FN_INSTR = 3'h2;
  localparam logic [2:0] FN_BOARD = 3'h3;
  localparam logic [2:0] FN_SUPPLY = 3'h4;

  // ----------------------------------------------------------------
  // reset values and identity
  // ----------------------------------------------------------------
  localparam logic [7:0] BOARD_ID_DEFAULT = 8'h5A; // arbitrary value
  localparam logic [7:1] MASK_RESET = 7'h00;
  localparam logic [2:0] LEVEL_NONE_N = 3'h7;
  localparam int ENC_CNT_W = 7;
  localparam logic [ENC_CNT_W-1:0] ENC_CNT_MAX = 7'h7F;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK, BUS_DONE, BUS_FAULT}
    iob_bus_state_t;
  typedef enum logic [1:0] {POR_IDLE, POR_WAIT, POR_PULSE} iob_por_state_t;

endpackage

/* File: verilog/iob_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none
// interrupt lines and mask control between board logic and encoder
interface iob_irq_if;
  logic [7:1] lines_n;
  logic mask_load;
  logic [7:1] mask_data;
  logic mask_clear;
  logic [2:0] level_n;
  modport source (output lines_n, output mask_load, output mask_data,
                  output mask_clear, input level_n);
  modport encoder (input lines_n, input mask_load, input mask_data,
                   input mask_clear, output level_n);
endinterface
`default_nettype wire

/* File: verilog/iob_irq_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module iob_irq_unit (
  input wire logic clock,
  input wire logic rst_n,
  iob_irq_if.encoder irq
);
  import iob_pkg::*;

  logic [7:1] mask;
  logic [7:1] next_mask;
  logic [2:0] level_n;
  logic [2:0] next_level_n;
  logic [7:1] masked_n;

  // ----------------------------------------------------------------
  // mask latch and priority encoder
  // ----------------------------------------------------------------
  // the clear wins over a load so a reset pulse always opens all lines
  always_comb begin
    next_mask = mask;
    if (irq.mask_clear) begin
      next_mask = MASK_RESET;
    end else if (irq.mask_load) begin
      next_mask = irq.mask_data;
    end
    masked_n = irq.lines_n | mask;
    next_level_n = LEVEL_NONE_N;
    // scan upward so the highest active line is the one that sticks
    for (int i = 1; i <= 7; i++) begin
      if (!masked_n[i]) begin
        next_level_n = ~3'(i);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask <= MASK_RESET;
      level_n <= LEVEL_NONE_N;
    end else begin
      mask <= next_mask;
      level_n <= next_level_n;
    end
  end

  assign irq.level_n = level_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  mask_clear_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    irq.mask_clear |=> (mask == MASK_RESET))
    else $error("mask not cleared by reset pulse");
  masked_quiet_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    (irq.mask_load && !irq.mask_clear && irq.mask_data == 7'h7F)
      |=> ##1 (level_n == LEVEL_NONE_N))
    else $error("masked line still reached the encoder");
  top_level_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    (!irq.lines_n[7] && !mask[7]) |=> (level_n == 3'h0))
    else $error("level seven not given precedence");
endmodule
`default_nettype wire

/* File: verilog/iob_io_board.sv */
`timescale 1ns/1ps
`default_nettype none
module iob_io_board #(
  parameter int POR_DELAY_CYC = iob_pkg::POR_DELAY_CYC,
  parameter int POR_PULSE_CYC = iob_pkg::POR_PULSE_CYC,
  parameter logic [7:0] BOARD_ID = iob_pkg::BOARD_ID_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic addr_top,
  input wire logic [3:0] slot_addr,
  input wire logic [2:0] func_addr,
  input wire logic addr_strobe_n,
  input wire logic read_not_write,
  input wire logic ext_ack_n,
  input wire logic [3:0] slot_identity_code,
  output logic data_buffer_en,
  output logic data_ack_n,
  output logic bus_fault_n,
  input wire logic [7:0] local_data_in,
  output logic [7:0] local_data_out,
  output logic local_data_oe,
  output logic keypad_read_n,
  output logic encoder_read_n,
  output logic supply_status_read_n,
  output logic instr_bus_sel_n,
  input wire logic osc_source,
  output logic [3:0] clk_out,
  input wire logic power_good,
  input wire logic reset_button_n,
  output logic sys_reset_n,
  input wire logic [5:0] supply_good,
  output logic supply_led,
  input wire logic enc_a,
  input wire logic enc_b,
  output logic encoder_irq,
  output logic [7:0] keypad_col_n,
  input wire logic [7:0] keypad_row_n,
  output logic keypad_irq,
  input wire logic [7:1] irq_lines_n,
  input wire logic [2:0] ctc_out,
  input wire logic mask_write_n,
  output logic [2:0] ipl_n
);
  import iob_pkg::*;

  localparam int SYNC_W = 53;
  // counter outputs idle low, every other pin idles high, so no false
  // interrupt or edge shows in the first cycles after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 53'h1F_FFFF_FFFF_F1FF;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic a23_s;
  logic [3:0] slot_s;
  logic [2:0] func_s;
  logic as_n_s;
  logic rnw_s;
  logic ext_ack_n_s;
  logic [3:0] id_s;
  logic osc_s;
  logic pwr_s;
  logic btn_n_s;
  logic [5:0] sup_s;
  logic [1:0] enc_s;
  logic [7:0] row_n_s;
  logic [7:1] irq_s;
  logic [2:0] ctc_s;
  logic mwr_n_s;
  logic [7:0] ld_s;

  // every pin passes two stages; only sync_b is ever decoded
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= SYNC_IDLE;
      sync_b <= SYNC_IDLE;
    end else begin
      sync_a <= {addr_top, slot_addr, func_addr, addr_strobe_n,
                 read_not_write, ext_ack_n, slot_identity_code, osc_source,
                 power_good, reset_button_n, supply_good, enc_a, enc_b,
                 keypad_row_n, irq_lines_n, ctc_out, mask_write_n,
                 local_data_in};
      sync_b <= sync_a;
    end
  end

  assign {a23_s, slot_s, func_s, as_n_s, rnw_s, ext_ack_n_s, id_s, osc_s,
          pwr_s, btn_n_s, sup_s, enc_s, row_n_s, irq_s, ctc_s, mwr_n_s,
          ld_s} = sync_b;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  iob_bus_state_t bus_state, next_bus_state;
  iob_por_state_t por_state, next_por_state;
  logic [WDOG_W-1:0] wdog, next_wdog;
  logic next_data_buffer_en, next_data_ack_n, next_bus_fault_n;
  logic [7:0] next_local_data_out;
  logic next_local_data_oe;
  logic next_keypad_read_n, next_encoder_read_n;
  logic next_supply_status_read_n, next_instr_bus_sel_n;
  logic osc_prev, next_osc_prev;
  logic [2:0] div, next_div;
  logic [3:0] next_clk_out;
  logic pwr_prev, next_pwr_prev, btn_prev, next_btn_prev;
  logic [POR_CNT_W-1:0] por_count, next_por_count;
  logic next_sys_reset_n, next_supply_led;
  logic [1:0] enc_prev, next_enc_prev;
  logic [ENC_CNT_W-1:0] enc_count, next_enc_count;
  logic enc_dir, next_enc_dir, next_encoder_irq;
  logic [2:0] key_col, next_key_col;
  logic [KEY_TMR_W-1:0] key_tmr, next_key_tmr;
  logic [7:0] key_code, next_key_code;
  logic key_down, next_key_down, scan_hit, next_scan_hit;
  logic [7:0] next_keypad_col_n;
  logic next_keypad_irq;
  logic mwr_prev, next_mwr_prev, mask_load, next_mask_load;
  logic [7:1] mask_data, next_mask_data;
  logic access, match, fn_ok, take, key_hit;
  logic rd_key, rd_enc;

  iob_irq_if irq_bus ();

  // index of the lowest active-low row
  function automatic logic [2:0] first_low(input logic [7:0] v);
    first_low = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (!v[i]) begin
        first_low = 3'(i);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_bus_state = bus_state;
    next_wdog = wdog;
    next_data_buffer_en = data_buffer_en;
    next_data_ack_n = data_ack_n;
    next_bus_fault_n = bus_fault_n;
    next_local_data_out = local_data_out;
    next_local_data_oe = local_data_oe;
    next_keypad_read_n = keypad_read_n;
    next_encoder_read_n = encoder_read_n;
    next_supply_status_read_n = supply_status_read_n;
    next_instr_bus_sel_n = instr_bus_sel_n;
    // backplane space only when the top address bit is high
    access = a23_s & ~as_n_s;
    match = access & (slot_s == id_s);
    fn_ok = (func_s <= FN_SUPPLY);
    take = (bus_state == BUS_IDLE) & match & fn_ok;
    rd_key = take & rnw_s & (func_s == FN_KEYPAD);
    rd_enc = take & rnw_s & (func_s == FN_ENCODER);
    unique case (bus_state)
      BUS_IDLE: begin
        if (!access) begin
          next_wdog = '0;
        end else if (match && fn_ok) begin
          next_bus_state = BUS_ACK;
          next_data_ack_n = 1'b0;
          next_data_buffer_en = 1'b1;
          next_keypad_read_n = ~(rnw_s & (func_s == FN_KEYPAD));
          next_encoder_read_n = ~(rnw_s & (func_s == FN_ENCODER));
          next_supply_status_read_n = ~(rnw_s & (func_s == FN_SUPPLY));
          next_instr_bus_sel_n = ~(func_s == FN_INSTR);
          // the instrument bus chip drives the bus itself on its reads
          next_local_data_oe = rnw_s & (func_s != FN_INSTR);
          unique case (func_s)
            FN_KEYPAD: next_local_data_out = key_code;
            FN_ENCODER: next_local_data_out = {enc_dir, enc_count};
            FN_BOARD: next_local_data_out = BOARD_ID;
            FN_SUPPLY: next_local_data_out = {&sup_s, 1'b0, sup_s};
            default: next_local_data_out = 8'h00;
          endcase
        end else if (!ext_ack_n_s) begin
          next_bus_state = BUS_DONE;
          next_wdog = '0;
        end else if (wdog == WDOG_LAST) begin
          next_bus_state = BUS_FAULT;
          next_bus_fault_n = 1'b0;
        end else begin
          next_wdog = wdog + 1'b1;
        end
      end
      BUS_ACK, BUS_DONE, BUS_FAULT: begin
        if (!access) begin
          next_bus_state = BUS_IDLE;
          next_wdog = '0;
          next_data_ack_n = 1'b1;
          next_bus_fault_n = 1'b1;
          next_data_buffer_en = 1'b0;
          next_local_data_oe = 1'b0;
          next_keypad_read_n = 1'b1;
          next_encoder_read_n = 1'b1;
          next_supply_status_read_n = 1'b1;
          next_instr_bus_sel_n = 1'b1;
        end
      end
    endcase

    // clock divider: source rises advance a binary counter
    next_osc_prev = osc_s;
    next_div = div;
    if (osc_s && !osc_prev) begin
      next_div = div + 1'b1;
    end
    next_clk_out = {next_div, osc_s};

    // power-on and pushbutton reset pulse
    next_pwr_prev = pwr_s;
    next_btn_prev = btn_n_s;
    next_por_state = por_state;
    next_por_count = por_count;
    next_sys_reset_n = sys_reset_n;
    if (!btn_n_s && btn_prev) begin
      next_por_state = POR_PULSE;
      next_por_count = '0;
    end else if (pwr_s != pwr_prev) begin
      next_por_state = POR_WAIT;
      next_por_count = '0;
    end else begin
      unique case (por_state)
        POR_IDLE: next_por_count = '0;
        POR_WAIT: begin
          if (por_count == POR_CNT_W'(POR_DELAY_CYC - 1)) begin
            next_por_state = POR_PULSE;
            next_por_count = '0;
          end else begin
            next_por_count = por_count + 1'b1;
          end
        end
        POR_PULSE: begin
          if (por_count == POR_CNT_W'(POR_PULSE_CYC - 1)) begin
            next_por_state = POR_IDLE;
            next_por_count = '0;
          end else begin
            next_por_count = por_count + 1'b1;
          end
        end
        default: next_por_state = POR_IDLE;
      endcase
    end
    next_sys_reset_n = (next_por_state != POR_PULSE);

    // supply indicator lit only when all six are good
    next_supply_led = &sup_s;

    // rotary encoder: count a-phase rises, b at that moment gives sense
    next_enc_prev = enc_s;
    next_enc_count = enc_count;
    next_enc_dir = enc_dir;
    next_encoder_irq = encoder_irq;
    if (rd_enc) begin
      next_enc_count = '0;
      next_encoder_irq = 1'b0;
    end
    if (enc_s[1] && !enc_prev[1]) begin
      next_enc_dir = enc_s[0];
      if (next_enc_count != ENC_CNT_MAX) begin
        next_enc_count = next_enc_count + 1'b1;
      end
      next_encoder_irq = 1'b1;
    end

    // keypad scan: each column held long enough for rows to settle
    next_key_col = key_col;
    next_key_tmr = key_tmr + 1'b1;
    next_key_code = key_code;
    next_key_down = key_down;
    next_scan_hit = scan_hit;
    next_keypad_irq = keypad_irq;
    key_hit = (key_tmr == KEY_TMR_LAST) & ~(&row_n_s);
    if (rd_key) begin
      next_keypad_irq = 1'b0;
    end
    if (key_tmr == KEY_TMR_LAST) begin
      next_key_tmr = '0;
      next_key_col = key_col + 1'b1;
      if (key_hit) begin
        next_scan_hit = 1'b1;
        if (!key_down) begin
          next_key_code = {2'b00, key_col, first_low(row_n_s)};
          next_key_down = 1'b1;
          next_keypad_irq = 1'b1;
        end
      end
      // a full silent sweep means the key was released
      if (key_col == 3'h7) begin
        next_scan_hit = 1'b0;
        if (!scan_hit && !key_hit) begin
          next_key_down = 1'b0;
        end
      end
    end
    next_keypad_col_n = ~(8'h01 << next_key_col);

    // mask write strobe from the processor's local decode
    next_mwr_prev = mwr_n_s;
    next_mask_load = ~mwr_n_s & mwr_prev;
    next_mask_data = mask_data;
    if (!mwr_n_s && mwr_prev) begin
      next_mask_data = ld_s[6:0];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= BUS_IDLE;
      wdog <= '0;
      data_buffer_en <= 1'b0;
      data_ack_n <= 1'b1;
      bus_fault_n <= 1'b1;
      local_data_out <= 8'h00;
      local_data_oe <= 1'b0;
      keypad_read_n <= 1'b1;
      encoder_read_n <= 1'b1;
      supply_status_read_n <= 1'b1;
      instr_bus_sel_n <= 1'b1;
      osc_prev <= 1'b1; // same level as the synchroniser after reset
      div <= 3'h0;
      clk_out <= 4'h0;
      pwr_prev <= 1'b0;
      btn_prev <= 1'b1;
      por_state <= POR_WAIT;
      por_count <= '0;
      sys_reset_n <= 1'b1;
      supply_led <= 1'b0;
      enc_prev <= 2'h3; // no phantom encoder step after reset
      enc_count <= '0;
      enc_dir <= 1'b0;
      encoder_irq <= 1'b0;
      key_col <= 3'h0;
      key_tmr <= '0;
      key_code <= 8'h00;
      key_down <= 1'b0;
      scan_hit <= 1'b0;
      keypad_col_n <= 8'hFE;
      keypad_irq <= 1'b0;
      mwr_prev <= 1'b1;
      mask_load <= 1'b0;
      mask_data <= MASK_RESET;
    end else begin
      bus_state <= next_bus_state;
      wdog <= next_wdog;
      data_buffer_en <= next_data_buffer_en;
      data_ack_n <= next_data_ack_n;
      bus_fault_n <= next_bus_fault_n;
      local_data_out <= next_local_data_out;
      local_data_oe <= next_local_data_oe;
      keypad_read_n <= next_keypad_read_n;
      encoder_read_n <= next_encoder_read_n;
      supply_status_read_n <= next_supply_status_read_n;
      instr_bus_sel_n <= next_instr_bus_sel_n;
      osc_prev <= next_osc_prev;
      div <= next_div;
      clk_out <= next_clk_out;
      pwr_prev <= next_pwr_prev;
      btn_prev <= next_btn_prev;
      por_state <= next_por_state;
      por_count <= next_por_count;
      sys_reset_n <= next_sys_reset_n;
      supply_led <= next_supply_led;
      enc_prev <= next_enc_prev;
      enc_count <= next_enc_count;
      enc_dir <= next_enc_dir;
      encoder_irq <= next_encoder_irq;
      key_col <= next_key_col;
      key_tmr <= next_key_tmr;
      key_code <= next_key_code;
      key_down <= next_key_down;
      scan_hit <= next_scan_hit;
      keypad_col_n <= next_keypad_col_n;
      keypad_irq <= next_keypad_irq;
      mwr_prev <= next_mwr_prev;
      mask_load <= next_mask_load;
      mask_data <= next_mask_data;
    end
  end

  // ----------------------------------------------------------------
  // interrupt combining and encoder
  // ----------------------------------------------------------------
  // own sources and counter outputs join the backplane lines wired-or
  assign irq_bus.lines_n = {irq_s[7], irq_s[6] & ~(|ctc_s), irq_s[5],
                            irq_s[4] & ~keypad_irq,
                            irq_s[3] & ~encoder_irq, irq_s[2:1]};
  assign irq_bus.mask_load = mask_load;
  assign irq_bus.mask_data = mask_data;
  assign irq_bus.mask_clear = ~sys_reset_n;
  assign ipl_n = irq_bus.level_n;

  iob_irq_unit u_irq (
    .clock(clock),
    .rst_n(rst_n),
    .irq(irq_bus.encoder)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_take;
    (bus_state == BUS_IDLE) && match && fn_ok;
  endsequence

  ack_on_match_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    s_take |=> (!data_ack_n && data_buffer_en) [*1] ##1 1'b1)
    else $error("selected access not acknowledged");
  buffer_slot_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    $rose(data_buffer_en) |-> $past(match))
    else $error("buffer enabled without slot match");
  board_id_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    (take && rnw_s && func_s == FN_BOARD)
      |=> (local_data_oe && local_data_out == BOARD_ID))
    else $error("board identity not presented");
  fault_time_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    (bus_state == BUS_IDLE && access && !(match && fn_ok) && ext_ack_n_s
      && wdog == WDOG_LAST) |=> !bus_fault_n)
    else $error("bus fault missing at timeout");
  no_early_fault_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    $fell(bus_fault_n) |-> $past(wdog) == WDOG_LAST)
    else $error("bus fault raised before timeout");
  reset_pulse_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    $fell(sys_reset_n) |-> ##1 !sys_reset_n [*8])
    else $error("reset pulse too short");
  key_irq_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    (key_hit && !key_down) |=> (keypad_irq && key_down))
    else $error("key closure did not interrupt");
  enc_irq_a:
  assert property (@(posedge clock) disable iff (!rst_n)
    (enc_s[1] && !enc_prev[1]) |=> encoder_irq)
    else $error("encoder activity did not interrupt");
endmodule
`default_nettype wire

/* File: sim/iob_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// processor on the backplane, one read access at a time
// ------------------------------------------------------------
module iob_cpu_model (
  input wire logic clock,
  input wire logic data_ack_n,
  input wire logic bus_fault_n,
  input wire logic [7:0] local_data_out,
  output logic addr_top,
  output logic [3:0] slot_addr,
  output logic [2:0] func_addr,
  output logic addr_strobe_n,
  output logic read_not_write
);
  // idle bus at time zero
  initial begin
    addr_top = 1'b0;
    slot_addr = 4'h0;
    func_addr = 3'h0;
    addr_strobe_n = 1'b1;
    read_not_write = 1'b1;
  end

  // request held until ack or fault is sampled low at an edge, or until 400 edges pass;
  // enter just after a rising edge
  task automatic rd(input logic [3:0] slot, input logic [2:0] fn,
                    output logic [7:0] data, output logic flt,
                    output int cyc);
    cyc = 0;
    addr_top <= 1'b1;
    slot_addr <= slot;
    func_addr <= fn;
    addr_strobe_n <= 1'b0;
    do begin
      @(posedge clock);
      cyc++;
    end while (data_ack_n !== 1'b0 && bus_fault_n !== 1'b0 && cyc < 400);
    data = local_data_out;
    flt = (bus_fault_n === 1'b0);
    // released address shows inverted values, never the stale ones
    addr_strobe_n <= 1'b1;
    addr_top <= 1'b0;
    slot_addr <= ~slot;
    func_addr <= ~fn;
    repeat (4) @(posedge clock);
  endtask
endmodule
`default_nettype wire

/* File: sim/io_board_bus_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module io_board_bus_control_test;
  import iob_pkg::*;
  localparam int PULSE = 40;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ext_ack_n = 1'b1, power_good = 1'b1, reset_button_n = 1'b1;
  logic osc_source = 1'b0, enc_a = 1'b0, enc_b = 1'b0, mask_write_n = 1'b1;
  logic key_down = 1'b0;
  logic [3:0] slot_identity_code = 4'h9;
  logic [7:0] local_data_in = 8'h00, keypad_row_n = 8'hFF;
  logic [5:0] supply_good = 6'h3F;
  logic [7:1] irq_lines_n = 7'h7F;
  logic [2:0] ctc_out = 3'h0;
  wire logic addr_top, addr_strobe_n, read_not_write;
  wire logic [3:0] slot_addr;
  wire logic [2:0] func_addr;
  logic data_buffer_en, data_ack_n, bus_fault_n, local_data_oe;
  logic sys_reset_n, supply_led, encoder_irq, keypad_irq;
  logic [7:0] local_data_out, keypad_col_n;
  logic [3:0] clk_out, p_clk;
  logic [2:0] ipl_n;
  logic keypad_read_n, encoder_read_n, supply_status_read_n, instr_bus_sel_n;
  logic [2:0] fn_seen;
  logic [7:0] sel_seen, sel_exp;
  int err_total, n_checks, cycles;
  int rises[4];

  iob_io_board #(.POR_DELAY_CYC(20), .POR_PULSE_CYC(PULSE)) u_dut (
    .clock, .rst_n, .addr_top, .slot_addr, .func_addr, .addr_strobe_n,
    .read_not_write, .ext_ack_n, .slot_identity_code, .data_buffer_en,
    .data_ack_n, .bus_fault_n, .local_data_in, .local_data_out,
    .local_data_oe, .keypad_read_n, .encoder_read_n,
    .supply_status_read_n, .instr_bus_sel_n, .osc_source, .clk_out,
    .power_good, .reset_button_n, .sys_reset_n, .supply_good, .supply_led,
    .enc_a, .enc_b, .encoder_irq, .keypad_col_n, .keypad_row_n,
    .keypad_irq, .irq_lines_n, .ctc_out, .mask_write_n, .ipl_n);

  iob_cpu_model u_cpu (.clock, .data_ack_n, .bus_fault_n, .local_data_out,
    .addr_top, .slot_addr, .func_addr, .addr_strobe_n, .read_not_write);

  // clock, slow source oscillator and one closed key at column 2, row 4
  always #20 clock = ~clock;
  always begin
    repeat (4) @(posedge clock);
    osc_source <= ~osc_source;
  end
  always @(posedge clock) begin
    keypad_row_n <= (key_down && keypad_col_n === 8'hFB) ? 8'hEF : 8'hFF;
  end

  // watch on the falling edge so posedge tasks never race the counts
  always @(negedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (clk_out[i] === 1'b1 && p_clk[i] === 1'b0) rises[i]++;
    end
    p_clk = clk_out;
    if (addr_strobe_n === 1'b0) fn_seen = func_addr;
    sel_seen = {2'h0, data_buffer_en, local_data_oe, keypad_read_n,
                encoder_read_n, supply_status_read_n, instr_bus_sel_n};
    // a read opens the buffer and exactly the addressed function
    sel_exp = {3'h1, fn_seen != FN_INSTR, fn_seen != FN_KEYPAD,
               fn_seen != FN_ENCODER, fn_seen != FN_SUPPLY,
               fn_seen != FN_INSTR};
    if (data_ack_n === 1'b0) begin
      check(sel_seen, sel_exp);
    end
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      tally_and_finish;
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait for the reset pulse to start, then count its low cycles
  task automatic pulse_len(output int n);
    int w;
    w = 0;
    n = 0;
    while (sys_reset_n !== 1'b0 && w < 200) begin
      @(posedge clock);
      w++;
    end
    while (sys_reset_n === 1'b0 && n < 200) begin
      @(posedge clock);
      n++;
    end
  endtask

  task automatic mask(input logic [7:0] v);
    local_data_in <= v;
    mask_write_n <= 1'b0;
    repeat (4) @(posedge clock);
    mask_write_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask

  task automatic run_all;
    logic [7:0] d;
    logic f;
    int c;
    int a[4];
    pulse_len(c);
    check(8'(c), 8'(PULSE));
    u_cpu.rd(4'h9, FN_BOARD, d, f, c);
    check(d, BOARD_ID_DEFAULT);
    check(f, 1'b0);
    u_cpu.rd(4'h9, FN_SUPPLY, d, f, c);
    check({d, supply_led}, {8'hBF, 1'b1});
    supply_good <= 6'h3E;
    u_cpu.rd(4'h9, FN_SUPPLY, d, f, c);
    check({d, supply_led}, {8'h3E, 1'b0});
    // unclaimed slot and unused function both end in a fault
    u_cpu.rd(4'h6, FN_BOARD, d, f, c);
    check({f, c >= 250 && c <= 260}, 2'h3);
    u_cpu.rd(4'h9, 3'h5, d, f, c);
    check(f, 1'b1);
    u_cpu.rd(4'h9, FN_INSTR, d, f, c);
    check(f, 1'b0);
    // another board's acknowledge keeps the watchdog quiet
    ext_ack_n <= 1'b0;
    u_cpu.rd(4'h6, FN_BOARD, d, f, c);
    ext_ack_n <= 1'b1;
    check({f, c == 400}, 2'h1);
    a = rises;
    repeat (128) @(posedge clock);
    for (int i = 0; i < 4; i++) check(8'(rises[i] - a[i]), 8'(16 >> i));
    enc_b <= 1'b1;
    repeat (3) begin
      enc_a <= 1'b1;
      repeat (4) @(posedge clock);
      enc_a <= 1'b0;
      repeat (4) @(posedge clock);
    end
    check({encoder_irq, ipl_n}, {1'b1, 3'h4});
    irq_lines_n <= 7'h6F;
    repeat (6) @(posedge clock);
    check(ipl_n, 3'h2);
    mask(8'h10);
    check(ipl_n, 3'h4);
    ctc_out <= 3'h2;
    repeat (6) @(posedge clock);
    check(ipl_n, 3'h1);
    ctc_out <= 3'h0;
    u_cpu.rd(4'h9, FN_ENCODER, d, f, c);
    check({d, encoder_irq}, {8'h83, 1'b0});
    reset_button_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_button_n <= 1'b1;
    pulse_len(c);
    check(8'(c), 8'(PULSE));
    repeat (4) @(posedge clock);
    check(ipl_n, 3'h2);
    irq_lines_n <= 7'h3F;
    repeat (6) @(posedge clock);
    check(ipl_n, 3'h0);
    mask(8'h7F);
    check(ipl_n, 3'h7);
    irq_lines_n <= 7'h7F;
    key_down <= 1'b1;
    for (int i = 0; i < 2000 && keypad_irq !== 1'b1; i++) @(posedge clock);
    check(keypad_irq, 1'b1);
    key_down <= 1'b0;
    u_cpu.rd(4'h9, FN_KEYPAD, d, f, c);
    check({d, keypad_irq}, {8'h14, 1'b0});
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset for twelve cycles, then the whole sequence
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    run_all;
    tally_and_finish;
  end
endmodule
`default_nettype wire
